// *** logic/complex_logic_array_mc_pkg.sv ***
`default_nettype none
package complex_logic_array_mc_pkg;
  localparam int NUM_OMC  = 16;
  localparam int GROUP    = 8;
  localparam int NUM_IMC  = 24;
  localparam int NUM_ECS  = 8;
  localparam int NUM_PT   = 56;
  localparam int NIB      = 6;
  // native terms per cell and where each group starts in the term pool
  localparam int NATIVE_A = 3;
  localparam int NATIVE_B = 4;
  localparam int PT_B_BASE = 24;
  // terms a cell may take from its lower and upper neighbour
  localparam int LEND_A      = 3;
  localparam int LEND_B_LO   = 2;
  localparam int LEND_B_HI   = 3;
  localparam int LEND_UPPER  = 3;
  localparam int B_LO_LAST   = 11;
  // word locations inside the i/o register space (low address byte)
  localparam logic [7:0] OFS_IMC_AB = 8'h18;
  localparam logic [7:0] OFS_IMC_C  = 8'h1a;
  localparam logic [7:0] OFS_OMC    = 8'h20;
  localparam logic [7:0] OFS_MASK   = 8'h22;
  localparam logic [7:0] MASK_RESET = 8'h00;

  typedef enum logic [1:0] {ROUTE_OWN, ROUTE_TO_LOWER, ROUTE_TO_UPPER, ROUTE_NONE} pt_route_t;
  typedef enum logic [1:0] {IMC_PASS, IMC_LATCH, IMC_REG} imc_mode_t;

  typedef struct packed {
    logic        address_latch_strobe;
    logic        write_strobe_low_n;
    logic        read_strobe_n;
    logic        io_register_space_select;
    logic [15:0] address_data_port;
  } host_bus_t;

  typedef struct packed {
    pt_route_t [NUM_PT-1:0] route;
    logic [15:0] invert;
    logic [15:0] registered;
    logic [15:0] internal_node;
    logic [15:0] pld_output;
    logic [15:0] oe_eq_defined;
    logic [15:0] clk_from_pin;
    logic [15:0] expand_en;
  } omc_cfg_t;

  typedef struct packed {
    imc_mode_t [NUM_IMC-1:0] mode;
    logic [NIB-1:0]          strobe_sel;
  } imc_cfg_t;

  typedef struct packed {
    logic [15:0]        q;
    logic [7:0]         mask_a;
    logic [7:0]         mask_b;
    logic [15:0]        addr;
    logic [15:0]        data_d;
    logic               wr_n_d;
    logic [15:0]        clkpt_d;
    logic               clkin_d;
    logic [NUM_IMC-1:0] imc_q;
    logic [NIB-1:0]     strobe_d;
    logic [15:0]        expand_q;
    logic [15:0]        ad_out;
    logic               ad_oe;
    logic [15:0]        pin;
    logic [15:0]        pin_oe;
    logic [15:0]        fb;
    logic [NUM_ECS-1:0] ecs;
    logic [NUM_ECS-1:0] ecs_oe;
  } state_t;
endpackage
`default_nettype wire

// *** logic/complex_logic_array_macrocell_mcu_access.sv ***
// Overview of operation
// - group A cells: three native, at most six borrowed terms
// - B0-B3: four native, at most five borrowed
// - B4-B7: four native, at most six borrowed
// - terms exclusive; borrowing only from neighbours
// - expansion through another cell adds delay
// - sixteen flip-flops loaded and read by host
// - host load overrides preset, clear and clock
// - load on trailing edge of write strobe
// - per-group write masks, reset to zero
// - mask bit one blocks that cell's load
// - pin enable is term OR direction bit
// - output without enable equation drives from power-up
// - internal node feeds back, pin left free
// - 24 input cells: latch, register or pass
// - host reads input cells through read buffer
// - input strobe: product term or address strobe
// - one strobe term per nibble of port
// - address strobe captures address bits above A15
// - eight external selects, one term, polarity
// - select pin enabled by term or direction
// - address latched while address strobe pulses
// - drive shared port only on selected read
`timescale 1ns/1ps
`default_nettype none
module complex_logic_array_macrocell_mcu_access (
  input  wire logic                                CLK,         // 50 MHz system clock
  input  wire logic                                NRST,        // async reset, active low
  input  wire complex_logic_array_mc_pkg::host_bus_t              BUS,         // host strobes and shared port input
  input  wire logic                                BIG_ENDIAN,  // host puts even byte on high lane
  output var  logic [15:0]                         AD_OUT,      // shared port read data
  output var  logic                                AD_OE,       // shared port driver enable
  input  wire logic [complex_logic_array_mc_pkg::NUM_PT-1:0]      PT,          // and-array product terms
  input  wire complex_logic_array_mc_pkg::omc_cfg_t               OMC_CFG,     // output cell configuration
  input  wire logic [15:0]                         OE_PT,       // per-pin enable product term
  input  wire logic [15:0]                         DIR_REG,     // port direction bits
  input  wire logic [15:0]                         PRESET_PT,   // flip-flop preset terms
  input  wire logic [15:0]                         CLEAR_PT,    // flip-flop clear terms
  input  wire logic [15:0]                         CLOCK_PT,    // flip-flop clock terms
  input  wire logic                                CLKIN,       // external macrocell clock pin
  output var  logic [15:0]                         OMC_PIN,     // output cell pin values
  output var  logic [15:0]                         OMC_PIN_OE,  // output cell pin enables
  output var  logic [15:0]                         OMC_FEEDBACK,// feedback into and-array
  input  wire logic [complex_logic_array_mc_pkg::NUM_IMC-1:0]     IMC_PIN,     // ports a, b, c pin levels
  input  wire logic [complex_logic_array_mc_pkg::NIB-1:0]         IMC_PT,      // per-nibble strobe terms
  input  wire complex_logic_array_mc_pkg::imc_cfg_t               IMC_CFG,     // input cell configuration
  output var  logic [complex_logic_array_mc_pkg::NUM_IMC-1:0]     IMC_BUS,     // input cells onto logic bus
  input  wire logic [complex_logic_array_mc_pkg::NUM_ECS-1:0]     ECS_PT,      // select product terms
  input  wire logic [complex_logic_array_mc_pkg::NUM_ECS-1:0]     ECS_POL,     // 1 = select active low
  input  wire logic [complex_logic_array_mc_pkg::NUM_ECS-1:0]     ECS_OE_PT,   // select enable terms
  input  wire logic [complex_logic_array_mc_pkg::NUM_ECS-1:0]     ECS_DIR,     // select direction bits
  output var  logic [complex_logic_array_mc_pkg::NUM_ECS-1:0]     ECS_OUT,     // external select levels
  output var  logic [complex_logic_array_mc_pkg::NUM_ECS-1:0]     ECS_OE       // external select enables
);

  complex_logic_array_mc_pkg::state_t st;
  complex_logic_array_mc_pkg::state_t next_st;
  logic [15:0]         sum;
  logic [15:0]         host_word;
  logic [15:0]         bus_view;
  logic                wr_done;
  logic                read_hit;
  logic [complex_logic_array_mc_pkg::NIB-1:0] strobe;

  // per-cell sum of product terms; each term has exactly one route
  // so a term in use by one cell is never seen by another
  genvar i;
  generate
    for (i = 0; i < complex_logic_array_mc_pkg::NUM_OMC; i++) begin : g_cell
      localparam bit IS_A     = (i < complex_logic_array_mc_pkg::GROUP);
      localparam int NAT      = IS_A ? complex_logic_array_mc_pkg::NATIVE_A : complex_logic_array_mc_pkg::NATIVE_B;
      localparam int BASE     = IS_A ? i * complex_logic_array_mc_pkg::NATIVE_A
                                     : complex_logic_array_mc_pkg::PT_B_BASE + (i - complex_logic_array_mc_pkg::GROUP) * complex_logic_array_mc_pkg::NATIVE_B;
      localparam bit HAS_LO   = (i % complex_logic_array_mc_pkg::GROUP) != 0;
      localparam bit HAS_UP   = (i % complex_logic_array_mc_pkg::GROUP) != complex_logic_array_mc_pkg::GROUP - 1;
      localparam int LO_BASE  = HAS_LO ? BASE - NAT : BASE;
      localparam int UP_BASE  = HAS_UP ? BASE + NAT : BASE;
      localparam int LEND_LO  = IS_A ? complex_logic_array_mc_pkg::LEND_A
                              : (i <= complex_logic_array_mc_pkg::B_LO_LAST) ? complex_logic_array_mc_pkg::LEND_B_LO
                              : complex_logic_array_mc_pkg::LEND_B_HI;
      logic s;
      always_comb begin
        s = 1'b0;
        for (int j = 0; j < complex_logic_array_mc_pkg::NATIVE_B; j++) begin
          // own native terms: 3 in group a, 4 in group b
          if (j < NAT && OMC_CFG.route[BASE + j] == complex_logic_array_mc_pkg::ROUTE_OWN) begin
            s = s | PT[BASE + j];
          end
          // borrowed from lower neighbour, capped so totals stay 6/5/6
          if (HAS_LO && j < LEND_LO && OMC_CFG.route[LO_BASE + j] == complex_logic_array_mc_pkg::ROUTE_TO_UPPER) begin
            s = s | PT[LO_BASE + j];
          end
          if (HAS_UP && j < complex_logic_array_mc_pkg::LEND_UPPER
              && OMC_CFG.route[UP_BASE + j] == complex_logic_array_mc_pkg::ROUTE_TO_LOWER) begin
            s = s | PT[UP_BASE + j];
          end
        end
      end
      // expansion goes through a registered copy of another cell's sum,
      // costing one cycle of delay for the expanded equation
      assign sum[i] = (s | (OMC_CFG.expand_en[i] & st.expand_q[i])) ^ OMC_CFG.invert[i];
    end
  endgenerate

  // host word to cell order; big-endian hosts carry group a on the high lane
  assign bus_view  = BIG_ENDIAN ? {st.data_d[7:0], st.data_d[15:8]}
                                : st.data_d;
  assign host_word = bus_view;
  // trailing edge: strobe was low last cycle and is high now
  assign wr_done   = ~st.wr_n_d & BUS.write_strobe_low_n & BUS.io_register_space_select;
  assign read_hit  = (st.addr[7:0] == complex_logic_array_mc_pkg::OFS_OMC) || (st.addr[7:0] == complex_logic_array_mc_pkg::OFS_MASK)
                  || (st.addr[7:0] == complex_logic_array_mc_pkg::OFS_IMC_AB) || (st.addr[7:0] == complex_logic_array_mc_pkg::OFS_IMC_C);

  // nibble strobe select: product term or host address strobe
  always_comb begin
    for (int k = 0; k < complex_logic_array_mc_pkg::NIB; k++) begin
      strobe[k] = IMC_CFG.strobe_sel[k] ? BUS.address_latch_strobe : IMC_PT[k];
    end
  end

  always_comb begin
    logic [15:0] rd;
    logic [15:0] mask;
    logic        clk_edge;
    logic        pad_data;
    rd       = 16'h0000;
    mask     = 16'h0000;
    clk_edge = 1'b0;
    pad_data = 1'b0;
    next_st  = st;

    // edge history sampled every cycle
    next_st.wr_n_d   = BUS.write_strobe_low_n;
    next_st.clkpt_d  = CLOCK_PT;
    next_st.clkin_d  = CLKIN;
    next_st.strobe_d = strobe;
    // data stays valid up to the strobe's rising edge, so keep it while low
    if (~BUS.write_strobe_low_n) begin
      next_st.data_d = BUS.address_data_port;
    end

    // address captured while the strobe is high, held after it falls
    if (BUS.address_latch_strobe) begin
      next_st.addr = BUS.address_data_port;
    end

    // expansion stage: each cell may draw on the next cell's sum
    for (int c = 0; c < complex_logic_array_mc_pkg::NUM_OMC; c++) begin
      next_st.expand_q[c] = sum[(c + 1) % complex_logic_array_mc_pkg::NUM_OMC];
    end

    // mask register writes
    if (wr_done && st.addr[7:0] == complex_logic_array_mc_pkg::OFS_MASK) begin
      next_st.mask_a = host_word[7:0];
      next_st.mask_b = host_word[15:8];
    end
    mask = {st.mask_b, st.mask_a};

    // output cell flip-flops: host load first, then clear, preset, clock
    for (int c = 0; c < complex_logic_array_mc_pkg::NUM_OMC; c++) begin
      clk_edge = OMC_CFG.clk_from_pin[c] ? (CLKIN & ~st.clkin_d)
                                         : (CLOCK_PT[c] & ~st.clkpt_d[c]);
      if (wr_done && st.addr[7:0] == complex_logic_array_mc_pkg::OFS_OMC && !mask[c]) begin
        next_st.q[c] = host_word[c];
      end else if (CLEAR_PT[c]) begin
        next_st.q[c] = 1'b0;
      end else if (PRESET_PT[c]) begin
        next_st.q[c] = 1'b1;
      end else if (clk_edge) begin
        next_st.q[c] = sum[c];
      end
    end

    // cell output mux, feedback and pin enable
    for (int c = 0; c < complex_logic_array_mc_pkg::NUM_OMC; c++) begin
      pad_data       = OMC_CFG.registered[c] ? st.q[c] : sum[c];
      next_st.fb[c]  = pad_data;
      next_st.pin[c] = OMC_CFG.internal_node[c] ? 1'b0 : pad_data;
      // an internal node leaves the pin to the port's other functions
      next_st.pin_oe[c] = ~OMC_CFG.internal_node[c]
                        & (OE_PT[c] | DIR_REG[c]
                           | (OMC_CFG.pld_output[c] & ~OMC_CFG.oe_eq_defined[c]));
    end

    // input cells; a latch is transparent while its strobe is high
    for (int n = 0; n < complex_logic_array_mc_pkg::NUM_IMC; n++) begin
      unique case (IMC_CFG.mode[n])
        complex_logic_array_mc_pkg::IMC_LATCH: begin
          if (strobe[n / 4]) begin
            next_st.imc_q[n] = IMC_PIN[n];
          end
        end
        complex_logic_array_mc_pkg::IMC_REG: begin
          if (strobe[n / 4] & ~st.strobe_d[n / 4]) begin
            next_st.imc_q[n] = IMC_PIN[n];
          end
        end
        default: begin
          next_st.imc_q[n] = IMC_PIN[n];
        end
      endcase
    end

    // external selects: one term each, polarity chosen per output
    next_st.ecs    = ECS_PT ^ ECS_POL;
    next_st.ecs_oe = ECS_OE_PT | ECS_DIR;

    // read buffer onto the shared port
    unique case (st.addr[7:0])
      complex_logic_array_mc_pkg::OFS_OMC:    rd = st.q;
      complex_logic_array_mc_pkg::OFS_MASK:   rd = mask;
      complex_logic_array_mc_pkg::OFS_IMC_AB: rd = st.imc_q[15:0];
      complex_logic_array_mc_pkg::OFS_IMC_C:  rd = {8'h00, st.imc_q[23:16]};
      default:                 rd = 16'h0000;
    endcase
    next_st.ad_out = BIG_ENDIAN ? {rd[7:0], rd[15:8]} : rd;
    // driven only while one of our locations is selected and read is low
    next_st.ad_oe  = BUS.io_register_space_select & ~BUS.read_strobe_n & read_hit;
  end

  // single state register; everything resets to constants
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st          <= '0;
      st.wr_n_d   <= 1'b1;
      st.mask_a   <= complex_logic_array_mc_pkg::MASK_RESET;
      st.mask_b   <= complex_logic_array_mc_pkg::MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs are register fields only
  assign AD_OUT       = st.ad_out;
  assign AD_OE        = st.ad_oe;
  assign OMC_PIN      = st.pin;
  assign OMC_PIN_OE   = st.pin_oe;
  assign OMC_FEEDBACK = st.fb;
  assign IMC_BUS      = st.imc_q;
  assign ECS_OUT      = st.ecs;
  assign ECS_OE       = st.ecs_oe;

endmodule
`default_nettype wire

// *** testbench/complex_logic_array_mc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module complex_logic_array_mc_checker (
  input wire logic                  CLK,        // system clock
  input wire logic                  NRST,       // async reset, active low
  input wire complex_logic_array_mc_pkg::host_bus_t BUS,       // host strobes and port
  input wire logic                  AD_OE,      // port driver enable
  input wire complex_logic_array_mc_pkg::omc_cfg_t OMC_CFG,    // output cell setup
  input wire logic [15:0]           OE_PT,      // pin enable terms
  input wire logic [15:0]           DIR_REG,    // direction bits
  input wire logic [15:0]           OMC_PIN_OE, // pin enables
  input wire logic [7:0]            ECS_PT,     // select terms
  input wire logic [7:0]            ECS_POL,    // select polarity
  input wire logic [7:0]            ECS_OE_PT,  // select enable terms
  input wire logic [7:0]            ECS_DIR,    // select direction bits
  input wire logic [7:0]            ECS_OUT,    // select levels
  input wire logic [7:0]            ECS_OE      // select enables
);
  logic [7:0] lat;
  logic       hit;
  logic       rd_on;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // own copy of the latched low address byte, so a hit is judged independently
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lat <= 8'h00;
    end else if (BUS.address_latch_strobe) begin
      lat <= BUS.address_data_port[7:0];
    end
  end
  // selected read at one of the four mapped words
  assign hit = (lat == complex_logic_array_mc_pkg::OFS_IMC_AB) || (lat == complex_logic_array_mc_pkg::OFS_IMC_C)
            || (lat == complex_logic_array_mc_pkg::OFS_OMC) || (lat == complex_logic_array_mc_pkg::OFS_MASK);
  assign rd_on = BUS.io_register_space_select && !BUS.read_strobe_n && hit;

  a_ecs_level: assert property ($past(NRST) |-> ECS_OUT == $past(ECS_PT ^ ECS_POL))
    else $error("select level differs from term and polarity");
  a_ecs_enable: assert property ($past(NRST) |-> ECS_OE == $past(ECS_OE_PT | ECS_DIR))
    else $error("select enable differs from term or direction");
  a_dir_enable: assert property ($past(NRST) |-> ($past(DIR_REG) & ~OMC_PIN_OE) == 16'h0000)
    else $error("direction bit did not enable pin");
  a_term_enable: assert property ($past(NRST) |->
    ($past(OE_PT & OMC_CFG.oe_eq_defined & ~OMC_CFG.internal_node) & ~OMC_PIN_OE) == 16'h0000)
    else $error("enable term did not enable pin");
  a_pin_quiet: assert property ($past(NRST) |->
    (OMC_PIN_OE & ~$past(DIR_REG | OE_PT | OMC_CFG.pld_output)) == 16'h0000)
    else $error("pin enabled with no cause");
  a_power_up_drive: assert property ($past(NRST) |->
    ($past(OMC_CFG.pld_output & ~OMC_CFG.oe_eq_defined & ~OMC_CFG.internal_node) & ~OMC_PIN_OE) == 16'h0000)
    else $error("output without enable equation not driven");
  a_read_drive: assert property ($past(NRST) |-> AD_OE == $past(rd_on))
    else $error("port drive does not follow selected read");
  a_read_stands: assert property (rd_on [*3] |=> AD_OE && $past(AD_OE))
    else $error("port drive dropped during read");
  a_read_release: assert property ($rose(BUS.read_strobe_n) |=> !AD_OE)
    else $error("port still driven after read ended");
  c_read: cover property (rd_on ##1 AD_OE);
  c_write: cover property ($rose(BUS.write_strobe_low_n) && BUS.io_register_space_select);
  c_select: cover property ($rose(ECS_OE));
endmodule
bind complex_logic_array_macrocell_mcu_access complex_logic_array_mc_checker u_complex_logic_array_mc_checker (
  .CLK(CLK), .NRST(NRST), .BUS(BUS), .AD_OE(AD_OE), .OMC_CFG(OMC_CFG), .OE_PT(OE_PT),
  .DIR_REG(DIR_REG), .OMC_PIN_OE(OMC_PIN_OE), .ECS_PT(ECS_PT), .ECS_POL(ECS_POL),
  .ECS_OE_PT(ECS_OE_PT), .ECS_DIR(ECS_DIR), .ECS_OUT(ECS_OUT), .ECS_OE(ECS_OE)
);
`default_nettype wire

// *** testbench/host_mcu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input  wire logic                   CLK,    // system clock
  input  wire logic [15:0]            AD_OUT, // device read data
  input  wire logic                   AD_OE,  // device drives port
  output var  complex_logic_array_mc_pkg::host_bus_t BUS     // strobes and shared port
);
  // idle bus: strobes inactive, nothing selected
  initial begin
    BUS = '0;
    BUS.write_strobe_low_n = 1'b1;
    BUS.read_strobe_n = 1'b1;
  end
  // address phase: strobe pulses while the address sits on the port
  task automatic addr(input logic [7:0] a);
    @(posedge CLK);
    BUS.address_latch_strobe <= 1'b1;
    BUS.address_data_port    <= {8'h00, a};
    @(posedge CLK);
    BUS.address_latch_strobe <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr(a);
    BUS.io_register_space_select <= 1'b1;
    BUS.write_strobe_low_n       <= 1'b0;
    BUS.address_data_port        <= d;
    @(posedge CLK);
    BUS.write_strobe_low_n <= 1'b1;
    @(posedge CLK);
    BUS.io_register_space_select <= 1'b0;
    BUS.address_data_port        <= ~d; // released port must not keep stale data
  endtask
  // read waits a bounded time for the drive; unmapped words never answer
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic oe);
    addr(a);
    BUS.io_register_space_select <= 1'b1;
    BUS.read_strobe_n            <= 1'b0;
    BUS.address_data_port        <= ~BUS.address_data_port;
    oe = 1'b0;
    d  = 16'h0000;
    for (int i = 0; i < 4 && !oe; i++) begin
      @(posedge CLK);
      oe = AD_OE;
      d  = AD_OUT;
    end
    @(posedge CLK);
    BUS.io_register_space_select <= 1'b0;
    BUS.read_strobe_n            <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                   clk, nrst, big_endian, clkin, ad_oe;
  complex_logic_array_mc_pkg::host_bus_t bus;
  complex_logic_array_mc_pkg::omc_cfg_t  omc_cfg;
  complex_logic_array_mc_pkg::imc_cfg_t  imc_cfg;
  logic [55:0]            pt;
  logic [15:0]            ad_out, oe_pt, dir_reg, preset_pt, clear_pt, clock_pt, omc_pin, omc_pin_oe, rdata;
  logic [23:0]            imc_pin, imc_bus;
  logic [15:0]            omc_fb;
  logic [5:0]             imc_pt;
  logic [7:0]             ecs_pt, ecs_pol, ecs_oe_pt, ecs_dir, ecs_out, ecs_oe;
  logic                   oe;
  int                     n_errors = 0;
  int                     comparisons = 0;

  complex_logic_array_macrocell_mcu_access u_complex_logic_array_macrocell_mcu_access (
    .CLK(clk), .NRST(nrst), .BUS(bus), .BIG_ENDIAN(big_endian), .AD_OUT(ad_out), .AD_OE(ad_oe),
    .PT(pt), .OMC_CFG(omc_cfg), .OE_PT(oe_pt), .DIR_REG(dir_reg), .PRESET_PT(preset_pt),
    .CLEAR_PT(clear_pt), .CLOCK_PT(clock_pt), .CLKIN(clkin), .OMC_PIN(omc_pin), .OMC_PIN_OE(omc_pin_oe),
    .OMC_FEEDBACK(omc_fb), .IMC_PIN(imc_pin), .IMC_PT(imc_pt), .IMC_CFG(imc_cfg), .IMC_BUS(imc_bus), .ECS_PT(ecs_pt),
    .ECS_POL(ecs_pol), .ECS_OE_PT(ecs_oe_pt), .ECS_DIR(ecs_dir), .ECS_OUT(ecs_out), .ECS_OE(ecs_oe)
  );
  host_mcu_model u_host_mcu_model (.CLK(clk), .AD_OUT(ad_out), .AD_OE(ad_oe), .BUS(bus));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // read a word and compare both the drive and, when a drive is expected, the data
  task automatic expect_rd(input logic [7:0] a, input logic [15:0] exp, input logic exp_oe, input string what);
    logic [15:0] d;
    logic        o;
    u_host_mcu_model.rd(a, d, o);
    chk({15'h0000, o}, {15'h0000, exp_oe}, what);
    if (exp_oe) begin
      chk(d, exp, what);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial begin
    nrst = 1'b0; big_endian = 1'b0; clkin = 1'b0; pt = '0; omc_cfg = '0; imc_cfg = '0;
    omc_cfg.registered = 16'hffff;
    omc_cfg.pld_output = 16'hffff;
    oe_pt = '0; dir_reg = '0; preset_pt = '0; clear_pt = '0; clock_pt = '0;
    imc_pin = '0; imc_pt = '0; ecs_pt = '0; ecs_pol = '0; ecs_oe_pt = '0; ecs_dir = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    expect_rd(complex_logic_array_mc_pkg::OFS_MASK, 16'h0000, 1'b1, "mask reset");
    expect_rd(complex_logic_array_mc_pkg::OFS_OMC, 16'h0000, 1'b1, "cells reset");
    chk(omc_pin_oe, 16'hffff, "power-up enable");
    $display("test reset values done");
    u_host_mcu_model.wr(complex_logic_array_mc_pkg::OFS_OMC, 16'ha5c3);
    expect_rd(complex_logic_array_mc_pkg::OFS_OMC, 16'ha5c3, 1'b1, "cell load");
    chk(omc_pin, 16'ha5c3, "cell pins");
    u_host_mcu_model.wr(complex_logic_array_mc_pkg::OFS_MASK, 16'h800f);
    expect_rd(complex_logic_array_mc_pkg::OFS_MASK, 16'h800f, 1'b1, "mask readback");
    u_host_mcu_model.wr(complex_logic_array_mc_pkg::OFS_OMC, 16'hffff);
    expect_rd(complex_logic_array_mc_pkg::OFS_OMC, 16'hfff3, 1'b1, "masked load");
    $display("test load and mask done");
    big_endian <= 1'b1;
    expect_rd(complex_logic_array_mc_pkg::OFS_OMC, 16'hf3ff, 1'b1, "swapped cells");
    u_host_mcu_model.wr(complex_logic_array_mc_pkg::OFS_MASK, 16'h0000);
    u_host_mcu_model.wr(complex_logic_array_mc_pkg::OFS_OMC, 16'h0102);
    big_endian <= 1'b0;
    expect_rd(complex_logic_array_mc_pkg::OFS_OMC, 16'h0201, 1'b1, "swapped load");
    u_host_mcu_model.wr(8'h30, 16'hffff);
    expect_rd(8'h30, 16'h0000, 1'b0, "unmapped read");
    expect_rd(complex_logic_array_mc_pkg::OFS_OMC, 16'h0201, 1'b1, "unmapped write");
    $display("test byte lanes and unmapped done");
    // clear held on every cell, preset on cells 0-7; the host load still wins its edge
    clear_pt <= 16'hffff;
    preset_pt <= 16'h00ff;
    u_host_mcu_model.wr(complex_logic_array_mc_pkg::OFS_OMC, 16'h5a5a);
    @(posedge clk);
    #1 chk(omc_pin, 16'h5a5a, "load over clear");
    @(posedge clk);
    #1 chk(omc_pin, 16'h0000, "clear after load");
    clear_pt = '0;
    preset_pt = '0;
    $display("test load priority done");
    // low group gets an enable equation, high group keeps power-up drive
    @(posedge clk);
    omc_cfg.oe_eq_defined <= 16'h00ff;
    oe_pt <= 16'h0f0f;
    dir_reg <= 16'h0030;
    ecs_pt <= 8'h35;
    ecs_oe_pt <= 8'h03;
    ecs_dir <= 8'h50;
    imc_pin <= 24'h5c3a96;
    for (int k = 0; k < 2; k++) begin
      ecs_pol <= 8'h0f << (4 * k);
      repeat (2) @(posedge clk);
      #1 chk({8'h00, ecs_out}, {8'h00, 8'h35 ^ (8'h0f << (4 * k))}, "select level");
      chk({8'h00, ecs_oe}, 16'h0053, "select enable");
      chk(omc_pin_oe, 16'hff3f, "pin enables");
    end
    $display("test enables done");
    // term lent to the lower cell, cell 1 hidden as a node, cell 15 expands on cell 0
    omc_cfg.registered    <= 16'h0000;
    omc_cfg.internal_node <= 16'h0002;
    omc_cfg.expand_en     <= 16'h8000;
    omc_cfg.route[3]      <= complex_logic_array_mc_pkg::ROUTE_TO_LOWER;
    pt[3]                 <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(omc_pin, 16'h8001, "borrowed term and expansion");
    chk(omc_fb, 16'h8001, "feedback");
    chk(omc_pin_oe, 16'hff3d, "node pin free");
    $display("test terms done");
    expect_rd(complex_logic_array_mc_pkg::OFS_IMC_AB, 16'h3a96, 1'b1, "input cells a b");
    u_host_mcu_model.rd(complex_logic_array_mc_pkg::OFS_IMC_C, rdata, oe);
    chk({oe, 7'h00, rdata[7:0]}, 16'h805c, "input cells c");
    // bit 0 becomes a register clocked by the address strobe
    imc_cfg.mode[0]       <= complex_logic_array_mc_pkg::IMC_REG;
    imc_cfg.strobe_sel[0] <= 1'b1;
    imc_pin[0]            <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, imc_bus[0]}, 16'h0000, "held without strobe");
    expect_rd(complex_logic_array_mc_pkg::OFS_IMC_AB, 16'h3a97, 1'b1, "strobe capture");
    chk({15'h0000, imc_bus[0]}, 16'h0001, "captured onto logic bus");
    $display("test input cells done");
    print_verdict();
  end
endmodule
`default_nettype wire
